// *** regulator_i2c_slave.v ***
`timescale 1ns/100ps
`default_nettype none
`include "regulator_i2c_regs.vh"

module regulator_i2c_slave (
    input wire clk, // System clock, 20 MHz.
    input wire rstn, // Asynchronous reset, active low.
    input wire scl_in, // Bus clock pin level.
    input wire sda_in, // Bus data pin level.
    output reg sda_out_q, // Data pin drive value, always low.
    output reg sda_oe_n_q, // Data pin enable, low while pulling SDA low.
    input wire temp_warn_in, // High while die is above the warning level.
    input wire temp_hot_in, // High while die is above the shutdown level.
    input wire temp_cool_in, // High once die has cooled to the resume level.
    input wire analog_supply_input, // Analog supply lockout, high while below threshold.
    input wire logic_supply_uvlo_in, // Logic supply lockout, high while below threshold.
    output reg power_stage_en_q, // Power stage allowed to switch.
    output reg hs_mode_q, // High-speed settings active.
    output reg [8*`REG_COUNT-1:0] reg_bank_q // Register contents, index 0 lowest.
);

    // -------------------------------------------------------------------------
    // Protocol states
    // -------------------------------------------------------------------------
    localparam [3:0] ST_IDLE = 4'h0;
    localparam [3:0] ST_ADDR = 4'h1;
    localparam [3:0] ST_AACK = 4'h2;
    localparam [3:0] ST_RADDR = 4'h3;
    localparam [3:0] ST_RACK = 4'h4;
    localparam [3:0] ST_WDATA = 4'h5;
    localparam [3:0] ST_WACK = 4'h6;
    localparam [3:0] ST_RDATA = 4'h7;
    localparam [3:0] ST_MACK = 4'h8;
    localparam [3:0] ST_IGNORE = 4'h9;

    // Returns the byte seen by a read of the given index.
    function [7:0] read_byte;
        input [8*`REG_COUNT-1:0] bank;
        input [2:0] idx;
        begin
            if (idx >= `REG_IMPL_COUNT) begin
                read_byte = `REG_UNIMPL_VALUE;
            end else begin
                read_byte = bank[8*idx +: 8];
            end
        end
    endfunction

    // -------------------------------------------------------------------------
    // Input synchronisers
    // -------------------------------------------------------------------------
    reg [1:0] scl_sync_q;
    reg [1:0] sda_sync_q;
    reg scl_prev_q;
    reg sda_prev_q;
    reg [1:0] warn_sync_q;
    reg [1:0] hot_sync_q;
    reg [1:0] cool_sync_q;
    reg [1:0] auvlo_sync_q;
    reg [1:0] luvlo_sync_q;

    // Every pin passes two flip-flops; a third copy of SCL and SDA finds edges.
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            scl_sync_q <= 2'h3;
            sda_sync_q <= 2'h3;
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
            warn_sync_q <= 2'h0;
            hot_sync_q <= 2'h0;
            cool_sync_q <= 2'h0;
            auvlo_sync_q <= 2'h0;
            luvlo_sync_q <= 2'h0;
        end else begin
            scl_sync_q <= {scl_sync_q[0], scl_in};
            sda_sync_q <= {sda_sync_q[0], sda_in};
            scl_prev_q <= scl_sync_q[1];
            sda_prev_q <= sda_sync_q[1];
            warn_sync_q <= {warn_sync_q[0], temp_warn_in};
            hot_sync_q <= {hot_sync_q[0], temp_hot_in};
            cool_sync_q <= {cool_sync_q[0], temp_cool_in};
            auvlo_sync_q <= {auvlo_sync_q[0], analog_supply_input};
            luvlo_sync_q <= {luvlo_sync_q[0], logic_supply_uvlo_in};
        end
    end

    // -------------------------------------------------------------------------
    // Bus events
    // -------------------------------------------------------------------------
    wire scl_s = scl_sync_q[1];
    wire sda_s = sda_sync_q[1];
    wire scl_rise = scl_s & ~scl_prev_q;
    wire scl_fall = ~scl_s & scl_prev_q;
    wire start_det = scl_s & scl_prev_q & ~sda_s & sda_prev_q;
    wire stop_det = scl_s & scl_prev_q & sda_s & ~sda_prev_q;
    wire uvlo_any = auvlo_sync_q[1] | luvlo_sync_q[1];

    // -------------------------------------------------------------------------
    // Protocol engine
    // -------------------------------------------------------------------------
    reg [3:0] state_q;
    reg [3:0] cnt_q;
    reg [7:0] shift_q;
    reg [7:0] tx_q;
    reg [2:0] ptr_q;
    reg write_pulse_q;
    reg [7:0] wdata_q;
    reg [2:0] widx_q;

    // Bytes a read sends from the current and the next index.
    wire [7:0] rd_cur = read_byte(reg_bank_q, ptr_q);
    wire [7:0] rd_next = read_byte(reg_bank_q, ptr_q + 3'h1);

    // Start, stop and SCL edges drive the byte and acknowledge sequence.
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_q <= ST_IDLE;
            cnt_q <= 4'h0;
            shift_q <= 8'h00;
            tx_q <= 8'h00;
            ptr_q <= 3'h0;
            sda_out_q <= 1'b0;
            sda_oe_n_q <= 1'b1;
            hs_mode_q <= 1'b0;
            write_pulse_q <= 1'b0;
            wdata_q <= 8'h00;
            widx_q <= 3'h0;
        end else begin
            write_pulse_q <= 1'b0;
            sda_out_q <= 1'b0;
            if (luvlo_sync_q[1] | auvlo_sync_q[1]) begin
                state_q <= ST_IDLE;
                sda_oe_n_q <= 1'b1;
                hs_mode_q <= 1'b0;
                ptr_q <= 3'h0;
                cnt_q <= 4'h0;
            end else if (stop_det) begin
                state_q <= ST_IDLE;
                sda_oe_n_q <= 1'b1;
                hs_mode_q <= 1'b0;
            end else if (start_det) begin
                state_q <= ST_ADDR;
                sda_oe_n_q <= 1'b1;
                cnt_q <= 4'h0;
            end else if (scl_rise) begin
                // Data is sampled while SCL is high; the master keeps it stable.
                case (state_q)
                    ST_ADDR, ST_RADDR, ST_WDATA: begin
                        shift_q <= {shift_q[6:0], sda_s};
                        cnt_q <= cnt_q + 4'h1;
                    end
                    ST_RDATA: begin
                        cnt_q <= cnt_q + 4'h1;
                    end
                    ST_MACK: begin
                        if (sda_s) begin
                            state_q <= ST_IGNORE;
                        end
                    end
                    default: begin
                    end
                endcase
            end else if (scl_fall) begin
                case (state_q)
                    ST_ADDR: begin
                        if (cnt_q == 4'h8) begin
                            if (shift_q[7:1] == `SLAVE_ADDR) begin
                                sda_oe_n_q <= 1'b0;
                                state_q <= ST_AACK;
                                tx_q <= {7'h00, shift_q[0]};
                            end else if (shift_q[7:3] == `HS_CODE_TOP) begin
                                hs_mode_q <= 1'b1;
                                state_q <= ST_IGNORE;
                            end else begin
                                state_q <= ST_IGNORE;
                            end
                        end
                    end
                    ST_AACK: begin
                        cnt_q <= 4'h0;
                        if (tx_q[0]) begin
                            tx_q <= rd_cur;
                            sda_oe_n_q <= rd_cur[7];
                            state_q <= ST_RDATA;
                        end else begin
                            sda_oe_n_q <= 1'b1;
                            state_q <= ST_RADDR;
                        end
                    end
                    ST_RADDR: begin
                        if (cnt_q == 4'h8) begin
                            ptr_q <= shift_q[2:0];
                            sda_oe_n_q <= 1'b0;
                            state_q <= ST_RACK;
                        end
                    end
                    ST_WDATA: begin
                        if (cnt_q == 4'h8) begin
                            wdata_q <= shift_q;
                            sda_oe_n_q <= 1'b0;
                            state_q <= ST_WACK;
                        end
                    end
                    ST_RACK, ST_WACK: begin
                        if (state_q == ST_WACK) begin
                            write_pulse_q <= 1'b1;
                            widx_q <= ptr_q;
                            ptr_q <= ptr_q + 3'h1;
                        end
                        sda_oe_n_q <= 1'b1;
                        cnt_q <= 4'h0;
                        state_q <= ST_WDATA;
                    end
                    ST_RDATA: begin
                        if (cnt_q == 4'h8) begin
                            sda_oe_n_q <= 1'b1;
                            state_q <= ST_MACK;
                        end else begin
                            tx_q <= {tx_q[6:0], 1'b0};
                            sda_oe_n_q <= tx_q[6];
                        end
                    end
                    ST_MACK: begin
                        ptr_q <= ptr_q + 3'h1;
                        tx_q <= rd_next;
                        sda_oe_n_q <= rd_next[7];
                        cnt_q <= 4'h0;
                        state_q <= ST_RDATA;
                    end
                    default: begin
                        sda_oe_n_q <= 1'b1;
                    end
                endcase
            end
        end
    end

    // -------------------------------------------------------------------------
    // Thermal protection and register bank
    // -------------------------------------------------------------------------
    reg shutdown_q;
    wire wr_status = write_pulse_q & (widx_q == `STATUS_IDX);

    // Shutdown follows the hot and cool levels; power stage off when shut or locked out.
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            shutdown_q <= 1'b0;
            power_stage_en_q <= 1'b0;
        end else begin
            if (uvlo_any) begin
                shutdown_q <= 1'b0;
            end else if (hot_sync_q[1]) begin
                shutdown_q <= 1'b1;
            end else if (cool_sync_q[1]) begin
                shutdown_q <= 1'b0;
            end
            power_stage_en_q <= ~hot_sync_q[1] & ~(shutdown_q & ~cool_sync_q[1]) & ~uvlo_any;
        end
    end

    // Register writes, thermal flags and lockout defaults; shutdown leaves contents alone.
    integer i;
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            reg_bank_q <= {`REG_COUNT{`REG_DEFAULT}};
        end else if (uvlo_any) begin
            reg_bank_q <= {`REG_COUNT{`REG_DEFAULT}};
        end else begin
            for (i = 0; i < `REG_IMPL_COUNT; i = i + 1) begin
                if (write_pulse_q && widx_q == i[2:0] && i[2:0] != `STATUS_IDX) begin
                    reg_bank_q[8*i +: 8] <= wdata_q;
                end
            end
            reg_bank_q[8*`STATUS_IDX + `STAT_WARN_BIT] <= warn_sync_q[1];
            if (hot_sync_q[1]) begin
                reg_bank_q[8*`STATUS_IDX + `STAT_SHUT_BIT] <= 1'b1;
            end else if (wr_status && !wdata_q[`STAT_SHUT_BIT]) begin
                reg_bank_q[8*`STATUS_IDX + `STAT_SHUT_BIT] <= 1'b0;
            end
        end
    end

endmodule // regulator_i2c_slave
`default_nettype wire

// *** regulator_i2c_regs.vh ***
`ifndef REGULATOR_I2C_REGS_VH
`define REGULATOR_I2C_REGS_VH

// -----------------------------------------------------------------------------
// Bus addressing
// -----------------------------------------------------------------------------
// Fixed 7-bit slave address.
`define SLAVE_ADDR 7'h60
// Upper five bits of a high-speed master code.
`define HS_CODE_TOP 5'h01

// -----------------------------------------------------------------------------
// Register bank layout
// -----------------------------------------------------------------------------
// Number of register indices reachable through the 3-bit index.
`define REG_COUNT 8
// Indices at or above this value are not implemented and read as zero.
`define REG_IMPL_COUNT 6
// Index of the protection status register.
`define STATUS_IDX 3'h5
// Bit position of the thermal early-warning flag in the status register.
`define STAT_WARN_BIT 0
// Bit position of the latched thermal-shutdown flag in the status register.
`define STAT_SHUT_BIT 1
// Reset value of every implemented storage register.
`define REG_DEFAULT 8'h00
// Value returned for unimplemented register indices.
`define REG_UNIMPL_VALUE 8'h00

`endif

// *** regulator_i2c_slave_chk.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "regulator_i2c_regs.vh"
module regulator_i2c_slave_chk (
    input wire logic clk, // System clock.
    input wire logic rstn, // Reset, active low.
    input wire logic scl_in, // Bus clock level.
    input wire logic sda_in, // Bus data level.
    input wire logic sda_out_q, // Data drive value.
    input wire logic sda_oe_n_q, // Data enable, low pulls.
    input wire logic temp_warn_in, // Warning level.
    input wire logic temp_hot_in, // Shutdown level.
    input wire logic temp_cool_in, // Resume level.
    input wire logic analog_supply_input, // Analog lockout.
    input wire logic logic_supply_uvlo_in, // Logic lockout.
    input wire logic power_stage_en_q, // Power stage enable.
    input wire logic hs_mode_q, // High-speed settings.
    input wire logic [8*`REG_COUNT-1:0] reg_bank_q // Register bytes.
);
    // ------------------------------------------------------------------
    // Bus and protection properties
    // ------------------------------------------------------------------
    // All properties share the system clock and its reset.
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    property p_drive_low; sda_out_q == 1'b0; endproperty
    a_drive_low: assert property (p_drive_low) else $error("data drive not low");
    property p_hold_high; scl_in [*3] |-> $stable(sda_oe_n_q); endproperty
    a_hold_high: assert property (p_hold_high) else $error("data moved in clock high");
    property p_stop_free; scl_in && $rose(sda_in) |-> ##[1:6] sda_oe_n_q; endproperty
    a_stop_free: assert property (p_stop_free) else $error("bus held after stop");
    property p_stop_hs; scl_in && $rose(sda_in) |-> ##[1:6] !hs_mode_q; endproperty
    a_stop_hs: assert property (p_stop_hs) else $error("fast mode not back after stop");
    property p_hs_noack; $rose(hs_mode_q) |-> sda_oe_n_q [*8]; endproperty
    a_hs_noack: assert property (p_hs_noack) else $error("master code acknowledged");
    property p_warn; temp_warn_in [*4] |-> reg_bank_q[8*5+`STAT_WARN_BIT]; endproperty
    a_warn: assert property (p_warn) else $error("warning flag not set");
    property p_shut; temp_hot_in [*4] |-> reg_bank_q[8*5+`STAT_SHUT_BIT]; endproperty
    a_shut: assert property (p_shut) else $error("shutdown flag not set");
    property p_hot_off; temp_hot_in |-> ##[1:4] !power_stage_en_q; endproperty
    a_hot_off: assert property (p_hot_off) else $error("power stage on while hot");
    property p_alo;
        analog_supply_input |-> ##[1:4] (reg_bank_q == '0 && !power_stage_en_q);
    endproperty
    a_alo: assert property (p_alo) else $error("analog lockout did not clear");
    property p_dlo; logic_supply_uvlo_in |-> ##[1:4] reg_bank_q == '0; endproperty
    a_dlo: assert property (p_dlo) else $error("logic lockout did not clear");
endmodule // regulator_i2c_slave_chk
`default_nettype wire

// *** host_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module host_model (
    input wire logic clk, // Bench clock that times the bus phases.
    input wire logic sda, // Resolved data line.
    output var logic scl, // Bus clock, high when idle.
    output var logic sda_drv // Data drive, 1 releases the line.
);
    // ------------------------------------------------------------------
    // Bus phases, eight cycles (400 ns) a bit
    // ------------------------------------------------------------------
    // Both lines start released; the clock stands high between frames.
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end
    task automatic w(input int n);
        repeat (n) @(negedge clk);
    endtask
    // Start or repeated start: data falls while the clock is high.
    task automatic start();
        sda_drv = 1'b1;
        w(2);
        scl = 1'b1;
        w(4);
        sda_drv = 1'b0;
        w(4);
        scl = 1'b0;
        w(2);
    endtask
    // Stop: data rises while the clock is high.
    task automatic stop();
        sda_drv = 1'b0;
        w(2);
        scl = 1'b1;
        w(4);
        sda_drv = 1'b1;
        w(4);
    endtask
    // One bit cell; data changes only while the clock is low.
    task automatic bit_cell(input logic b, output logic seen);
        sda_drv = b;
        w(2);
        scl = 1'b1;
        w(2);
        seen = sda;
        w(2);
        scl = 1'b0;
        w(2);
    endtask
    // A byte out, most significant bit first, then the slave's acknowledge.
    task automatic send(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_cell(b[i], s);
        bit_cell(1'b1, s);
        ack = ~s;
    endtask
    // A byte in, then our acknowledge, or not-acknowledge on the last byte.
    task automatic recv(input logic last, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_cell(1'b1, s);
            b[i] = s;
        end
        bit_cell(last, s);
    endtask
endmodule // host_model
`default_nettype wire

// *** testbench.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "regulator_i2c_regs.vh"
module testbench;
    logic clk, rstn, temp_warn_in, temp_hot_in, temp_cool_in, ack;
    logic analog_supply_input, logic_supply_uvlo_in;
    logic [7:0] rv;
    int mismatches, total_checks, cycles;
    wire scl, sda_drv, sda_out_q, sda_oe_n_q, power_stage_en_q, hs_mode_q;
    wire [8*`REG_COUNT-1:0] reg_bank_q;
    // Open-drain data line with its pull-up.
    wire sda = sda_drv & (sda_oe_n_q | sda_out_q);
    regulator_i2c_slave regulator_i2c_slave_i (.clk(clk), .rstn(rstn), .scl_in(scl),
        .sda_in(sda), .sda_out_q(sda_out_q), .sda_oe_n_q(sda_oe_n_q),
        .temp_warn_in(temp_warn_in), .temp_hot_in(temp_hot_in), .temp_cool_in(temp_cool_in),
        .analog_supply_input(analog_supply_input), .logic_supply_uvlo_in(logic_supply_uvlo_in),
        .power_stage_en_q(power_stage_en_q), .hs_mode_q(hs_mode_q), .reg_bank_q(reg_bank_q));
    host_model host_model_i (.clk(clk), .sda(sda), .scl(scl), .sda_drv(sda_drv));
    // ------------------------------------------------------------------
    // Clock, timeout and helpers
    // ------------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // Cuts a hang short well beyond the expected run length.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 30000) begin
            mismatches++;
            summarize();
        end
    end
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Sets the thermal and supply levels seen by the block.
    task automatic drive_env(input logic warn, input logic hot, input logic cool,
        input logic alo, input logic dlo);
        temp_warn_in = warn;
        temp_hot_in = hot;
        temp_cool_in = cool;
        analog_supply_input = alo;
        logic_supply_uvlo_in = dlo;
    endtask
    function automatic logic [7:0] bk(input int i);
        return reg_bank_q[8*i +: 8];
    endfunction
    task automatic tx(input logic [7:0] b, input logic e);
        host_model_i.send(b, ack);
        chk("ack", {7'h00, e}, {7'h00, ack});
    endtask
    // Start, address with write, index, repeated start, address with read.
    task automatic rd_open(input logic [7:0] idx);
        host_model_i.start();
        tx(8'hc0, 1'b1);
        tx(idx, 1'b1);
        host_model_i.start();
        tx(8'hc1, 1'b1);
    endtask
    task automatic rd(input logic [7:0] idx, output logic [7:0] v);
        rd_open(idx);
        host_model_i.recv(1'b1, v);
        host_model_i.stop();
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        host_model_i.start();
        tx(8'hc0, 1'b1);
        tx(idx, 1'b1);
        tx(d, 1'b1);
        host_model_i.stop();
    endtask
    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_burst();
        for (int i = 0; i < 8; i++) chk("default", `REG_DEFAULT, bk(i));
        wr(8'h02, 8'ha5);
        tx(8'h3c, 1'b0);
        chk("reg2", 8'ha5, bk(2));
        host_model_i.start();
        tx(8'hc0, 1'b1);
        tx(8'h02, 1'b1);
        tx(8'ha5, 1'b1);
        tx(8'h3c, 1'b1);
        host_model_i.stop();
        chk("reg3", 8'h3c, bk(3));
        rd_open(8'h02);
        host_model_i.recv(1'b0, rv);
        chk("read2", 8'ha5, rv);
        host_model_i.recv(1'b1, rv);
        chk("read3", 8'h3c, rv);
        host_model_i.stop();
        wr(8'h06, 8'h77);
        rd(8'h06, rv);
        chk("unimpl", `REG_UNIMPL_VALUE, rv);
        $display("test burst done");
    endtask
    task automatic t_foreign();
        logic [7:0] a[3] = '{8'h00, 8'hf0, 8'hc2};
        for (int i = 0; i < 3; i++) begin
            host_model_i.start();
            tx(a[i], 1'b0);
            host_model_i.stop();
        end
        chk("hs idle", 8'h00, {7'h00, hs_mode_q});
        host_model_i.start();
        tx(8'h0b, 1'b0);
        chk("hs on", 8'h01, {7'h00, hs_mode_q});
        host_model_i.start();
        chk("hs kept", 8'h01, {7'h00, hs_mode_q});
        tx(8'hc0, 1'b1);
        tx(8'h00, 1'b1);
        tx(8'h11, 1'b1);
        host_model_i.stop();
        chk("hs off", 8'h00, {7'h00, hs_mode_q});
        chk("reg0", 8'h11, bk(0));
        $display("test address and speed done");
    endtask
    task automatic t_thermal();
        drive_env(1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
        host_model_i.w(6);
        chk("warn", 8'h01, bk(5) & 8'h01);
        drive_env(1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
        host_model_i.w(6);
        chk("pwr hot", 8'h00, {7'h00, power_stage_en_q});
        rd(8'h00, rv);
        chk("kept", 8'h11, rv);
        drive_env(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
        host_model_i.w(6);
        chk("pwr warm", 8'h00, {7'h00, power_stage_en_q});
        drive_env(1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
        host_model_i.w(6);
        chk("pwr cool", 8'h01, {7'h00, power_stage_en_q});
        chk("shut", 8'h02, bk(5) & 8'h02);
        wr(8'h05, 8'h00);
        chk("shut clr", 8'h00, bk(5) & 8'h02);
        drive_env(1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
        $display("test thermal done");
    endtask
    task automatic t_lockout();
        wr(8'h01, 8'h5a);
        drive_env(1'b0, 1'b0, 1'b1, 1'b1, 1'b0);
        host_model_i.w(6);
        chk("alo reg", 8'h00, bk(1));
        chk("alo pwr", 8'h00, {7'h00, power_stage_en_q});
        drive_env(1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
        wr(8'h01, 8'h5a);
        drive_env(1'b0, 1'b0, 1'b1, 1'b0, 1'b1);
        host_model_i.w(6);
        chk("dlo reg", 8'h00, bk(1));
        drive_env(1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
        host_model_i.w(6);
        rd(8'h01, rv);
        chk("after", `REG_DEFAULT, rv);
        $display("test lockout done");
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // Main sequence: reset for eight cycles, then the scenarios.
    initial begin
        rstn = 1'b0;
        drive_env(1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
        repeat (8) @(negedge clk);
        rstn = 1'b1;
        host_model_i.w(6);
        t_burst();
        t_foreign();
        t_thermal();
        t_lockout();
        summarize();
    end
endmodule // testbench
bind regulator_i2c_slave regulator_i2c_slave_chk regulator_i2c_slave_chk_i (.clk(clk),
    .rstn(rstn), .scl_in(scl_in), .sda_in(sda_in), .sda_out_q(sda_out_q),
    .sda_oe_n_q(sda_oe_n_q), .temp_warn_in(temp_warn_in), .temp_hot_in(temp_hot_in),
    .temp_cool_in(temp_cool_in), .analog_supply_input(analog_supply_input),
    .logic_supply_uvlo_in(logic_supply_uvlo_in), .power_stage_en_q(power_stage_en_q),
    .hs_mode_q(hs_mode_q), .reg_bank_q(reg_bank_q));
`default_nettype wire
